/* design/serial_control.v */
/*
 * serial control block: control register with transmit and receive
 * enables and interrupt enables, status flags, a minimal 8-bit
 * asynchronous transmitter and a receiver for asynchronous and clocked modes.
 * assumes a single 25 MHz clock, a one-cycle strobe register port,
 * and serial pins that are asynchronous to clk_in.
 */
//
// Summary of operation
// RL1: tx empty interrupt raised only while transmit interrupt enable bit 7 is one.
// RL2: tx empty interrupt drops when flag cleared after read, or enable cleared.
// RL3: receive interrupt enable bit 6 allows receive full and error interrupts.
// RL4: receive interrupts drop on flag clear after read one, or enable cleared.
// RL5: with transmit enable bit 5, sending starts after data write and flag clear.
// RL6: software programs the mode register before setting either enable bit.
// RL7: while transmit enable is zero the tx buffer empty flag stays one.
// RL8: with receive enable bit 4, receive on start bit or on sync clock.
// RL9: clearing receive enable leaves receive full and fault flags untouched.
// RL10: control register layout and reset identical whatever card select is.
// RL11: each source interrupt output is the level AND of its flag(s) and enable; irq_out is the OR of the three.
`include "serial_control_map.vh"

module serial_control (
	// clock and reset
	input wire clk_in,
	input wire arst_n_in,
	// register port
	input wire [2:0] addr_in,
	input wire [7:0] wdata_in,
	input wire wr_in,
	input wire rd_in,
	output reg [7:0] rdata_out,
	// serial line
	input wire rxd_in,
	input wire sck_in,
	output reg txd_out,
	// interrupts
	output wire tx_empty_irq_out,
	output wire rx_full_irq_out,
	output wire rx_error_irq_out,
	output wire irq_out
);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	localparam S_IDLE = 2'h0;
	localparam S_START = 2'h1;
	localparam S_DATA = 2'h2;
	localparam S_STOP = 2'h3;

	reg [7:0] serial_control_reg;
	reg [7:0] serial_mode_reg;
	reg [7:0] serial_status_reg;
	reg [7:0] tx_holding_reg;
	reg [7:0] rx_data;
	reg [7:0] card_mode_reg;
	reg [7:0] baud_div;
	// status bits seen as one by software, needed before a clear works
	reg [7:0] seen_one;

	wire tx_irq_on = serial_control_reg[`CTL_TX_IRQ_ON];
	wire rx_irq_on = serial_control_reg[`CTL_RX_IRQ_ON];
	wire tx_on = serial_control_reg[`CTL_TX_ON];
	wire rx_on = serial_control_reg[`CTL_RX_ON];
	wire sync_mode = serial_mode_reg[`MODE_SYNC];
	wire parity_on = serial_mode_reg[`MODE_PARITY_ON];
	wire parity_odd = serial_mode_reg[`MODE_PARITY_ODD];
	wire tx_buffer_empty = serial_status_reg[`ST_TX_EMPTY];
	wire rx_buffer_full = serial_status_reg[`ST_RX_FULL];
	wire error_any = serial_status_reg[`ST_OVERRUN] |
		serial_status_reg[`ST_FRAMING] | serial_status_reg[`ST_PARITY];

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	reg [1:0] rxd_sync;
	reg [1:0] sck_sync;
	reg sck_prev;
	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rxd_sync <= 2'h3;
			sck_sync <= 2'h3;
			sck_prev <= 1'b1;
		end else begin
			rxd_sync <= {rxd_sync[0], rxd_in};
			sck_sync <= {sck_sync[0], sck_in};
			sck_prev <= sck_sync[1];
		end
	end
	wire rxd = rxd_sync[1];
	wire sck_rise = sck_sync[1] & ~sck_prev;

	// ----------------------------------------------------------------
	// bit tick from baud divider
	// ----------------------------------------------------------------
	reg [7:0] baud_cnt;
	wire tick = (baud_cnt == 8'h00);
	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			baud_cnt <= 8'h00;
		else if (tick)
			baud_cnt <= baud_div;
		else
			baud_cnt <= baud_cnt - 8'h01;
	end

	// ----------------------------------------------------------------
	// transmitter
	// ----------------------------------------------------------------
	reg [1:0] tx_state;
	reg [2:0] tx_bit;
	reg [7:0] tx_shift;
	reg tx_par;
	reg tx_par_sent;
	wire tx_launch;
	// start only once software has released the holding register
	assign tx_launch = tx_on & ~tx_buffer_empty & (tx_state == S_IDLE) &
		tick; // see RL5
	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			tx_state <= S_IDLE;
			tx_bit <= 3'h0;
			tx_shift <= 8'h00;
			tx_par <= 1'b0;
			tx_par_sent <= 1'b0;
			txd_out <= 1'b1;
		end else if (!tx_on) begin
			tx_state <= S_IDLE;
			txd_out <= 1'b1;
		end else if (tick) begin
			case (tx_state)
			S_IDLE: begin
				if (tx_launch) begin
					tx_shift <= tx_holding_reg;
					tx_par <= parity_odd;
					tx_par_sent <= 1'b0;
					tx_state <= S_START;
					txd_out <= 1'b0;
				end
			end
			S_START: begin
				tx_bit <= 3'h0;
				txd_out <= tx_shift[0];
				tx_par <= tx_par ^ tx_shift[0];
				tx_shift <= {1'b0, tx_shift[7:1]};
				tx_state <= S_DATA;
			end
			S_DATA: begin
				if (tx_bit == 3'h7) begin
					if (parity_on && !tx_par_sent) begin
						txd_out <= tx_par;
						tx_par_sent <= 1'b1;
					end else begin
						txd_out <= 1'b1;
						tx_state <= S_STOP;
					end
				end else begin
					tx_bit <= tx_bit + 3'h1;
					txd_out <= tx_shift[0];
					tx_par <= tx_par ^ tx_shift[0];
					tx_shift <= {1'b0, tx_shift[7:1]};
				end
			end
			S_STOP: begin
				txd_out <= 1'b1;
				tx_state <= S_IDLE;
			end
			default: tx_state <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// receiver
	// ----------------------------------------------------------------
	// simplification: async sampling once per tick, no mid-bit centring
	reg [1:0] rx_state;
	reg [2:0] rx_bit;
	reg [7:0] rx_shift;
	reg rx_par;
	reg rx_par_done;
	reg rx_done;
	reg rx_frame_bad;
	reg rx_par_bad;
	wire rx_step = sync_mode ? sck_rise : tick;
	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rx_state <= S_IDLE;
			rx_bit <= 3'h0;
			rx_shift <= 8'h00;
			rx_par <= 1'b0;
			rx_par_done <= 1'b0;
			rx_done <= 1'b0;
			rx_frame_bad <= 1'b0;
			rx_par_bad <= 1'b0;
		end else begin
			rx_done <= 1'b0;
			if (!rx_on) begin
				rx_state <= S_IDLE;
			end else if (rx_step) begin
				case (rx_state)
				S_IDLE: begin
					rx_bit <= 3'h0;
					rx_par <= parity_odd;
					rx_par_done <= 1'b0;
					if (sync_mode) begin
						rx_shift <= {rxd, rx_shift[7:1]};
						rx_par <= parity_odd ^ rxd;
						rx_bit <= 3'h1;
						rx_state <= S_DATA; // see RL8
					end else if (!rxd) begin
						rx_state <= S_START; // see RL8
					end
				end
				S_START: begin
					rx_shift <= {rxd, rx_shift[7:1]};
					rx_par <= rx_par ^ rxd;
					rx_bit <= 3'h1;
					rx_state <= S_DATA;
				end
				S_DATA: begin
					if (rx_bit == 3'h0) begin
						if (!sync_mode && parity_on && !rx_par_done) begin
							rx_par_bad <= rx_par ^ rxd;
							rx_par_done <= 1'b1;
						end else begin
							rx_frame_bad <= ~sync_mode & ~rxd;
							if (!parity_on || sync_mode)
								rx_par_bad <= 1'b0;
							rx_done <= 1'b1;
							rx_state <= S_IDLE;
						end
					end else begin
						rx_shift <= {rxd, rx_shift[7:1]};
						rx_par <= rx_par ^ rxd;
						rx_bit <= rx_bit + 3'h1;
						if (sync_mode && rx_bit == 3'h7) begin
							rx_done <= 1'b1;
							rx_frame_bad <= 1'b0;
							rx_par_bad <= 1'b0;
							rx_state <= S_IDLE;
						end
					end
				end
				default: rx_state <= S_IDLE;
				endcase
			end
		end
	end
	// rx_done is registered, so the last shift has landed when it is seen
	wire [7:0] rx_word = rx_shift;

	// ----------------------------------------------------------------
	// register writes and status flags
	// ----------------------------------------------------------------
	wire wr_status = wr_in & (addr_in == `ADDR_STATUS);
	wire rd_status = rd_in & (addr_in == `ADDR_STATUS);
	reg [7:0] next_status;
	reg [7:0] clr_mask;
	always @* begin
		clr_mask = 8'h00;
		if (wr_status)
			clr_mask = seen_one & ~wdata_in;
		next_status = serial_status_reg & ~clr_mask; // see RL2, RL4
		// set wins over a clear arriving in the same cycle
		if (tx_launch) begin
			next_status[`ST_TX_EMPTY] = 1'b1;
			next_status[`ST_TX_DONE] = 1'b0;
		end
		if (tx_state == S_STOP && tick && tx_buffer_empty)
			next_status[`ST_TX_DONE] = 1'b1;
		if (!tx_on)
			next_status[`ST_TX_EMPTY] = 1'b1; // see RL7
		// fault flags are set only on a finished frame, never on rx_on
		if (rx_done) begin // see RL9
			if (rx_buffer_full) begin
				next_status[`ST_OVERRUN] = 1'b1;
			end else begin
				next_status[`ST_RX_FULL] = 1'b1;
				// faults are sticky: a later good frame never clears one
				if (rx_frame_bad)
					next_status[`ST_FRAMING] = 1'b1;
				if (rx_par_bad)
					next_status[`ST_PARITY] = 1'b1;
			end
		end
	end

	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			serial_control_reg <= `CTL_RESET;
			serial_mode_reg <= 8'h00;
			serial_status_reg <= `ST_RESET;
			tx_holding_reg <= 8'h00;
			rx_data <= 8'h00;
			card_mode_reg <= 8'h00;
			baud_div <= `BAUD_RESET;
			seen_one <= 8'h00;
		end else begin
			serial_status_reg <= next_status;
			if (rd_status)
				seen_one <= serial_status_reg;
			else if (wr_status)
				seen_one <= 8'h00;
			if (rx_done && !rx_buffer_full)
				rx_data <= rx_word;
			if (wr_in) begin
				case (addr_in)
				// card select changes no layout or reset of this register
				`ADDR_CONTROL: serial_control_reg <= wdata_in; // see RL10
				`ADDR_MODE: serial_mode_reg <= wdata_in; // see RL6
				`ADDR_TX_HOLD: tx_holding_reg <= wdata_in;
				`ADDR_CARD_MODE: card_mode_reg <= wdata_in;
				`ADDR_BAUD: baud_div <= wdata_in;
				default: ;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// read data and interrupts
	// ----------------------------------------------------------------
	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rdata_out <= 8'h00;
		end else if (rd_in) begin
			case (addr_in)
			`ADDR_CONTROL: rdata_out <= serial_control_reg;
			`ADDR_MODE: rdata_out <= serial_mode_reg;
			`ADDR_STATUS: rdata_out <= serial_status_reg;
			`ADDR_TX_HOLD: rdata_out <= tx_holding_reg;
			`ADDR_RX_DATA: rdata_out <= rx_data;
			`ADDR_CARD_MODE: rdata_out <= card_mode_reg;
			`ADDR_BAUD: rdata_out <= baud_div;
			default: rdata_out <= 8'h00;
			endcase
		end else begin
			rdata_out <= 8'h00;
		end
	end

	assign tx_empty_irq_out = tx_irq_on & tx_buffer_empty; // see RL1, RL11
	assign rx_full_irq_out = rx_irq_on & rx_buffer_full; // see RL3, RL11
	assign rx_error_irq_out = rx_irq_on & error_any; // see RL3, RL11
	assign irq_out = tx_empty_irq_out | rx_full_irq_out | rx_error_irq_out;

endmodule // serial_control

/* design/serial_control_map.vh */
/*
 * serial control block constants: register indices, control bit positions,
 * status bit positions, reset values and timing counts.
 * assumes inclusion by bare name from the design file only.
 */
`ifndef SERIAL_CONTROL_MAP_VH
`define SERIAL_CONTROL_MAP_VH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define ADDR_CONTROL 3'h0
`define ADDR_MODE 3'h1
`define ADDR_STATUS 3'h2
`define ADDR_TX_HOLD 3'h3
`define ADDR_RX_DATA 3'h4
`define ADDR_CARD_MODE 3'h5
`define ADDR_BAUD 3'h6

// ----------------------------------------------------------------
// control register bits
// ----------------------------------------------------------------
`define CTL_TX_IRQ_ON 7
`define CTL_RX_IRQ_ON 6
`define CTL_TX_ON 5
`define CTL_RX_ON 4
`define CTL_RESET 8'h00

// ----------------------------------------------------------------
// status register bits
// ----------------------------------------------------------------
`define ST_TX_EMPTY 7
`define ST_RX_FULL 6
`define ST_OVERRUN 5
`define ST_FRAMING 4
`define ST_PARITY 3
`define ST_TX_DONE 2
`define ST_RESET 8'h84

// ----------------------------------------------------------------
// mode register bits and timing
// ----------------------------------------------------------------
`define MODE_SYNC 7
`define MODE_PARITY_ON 5
`define MODE_PARITY_ODD 4
`define BAUD_RESET 8'h0F
`define CARD_SELECT 0

`endif

/* test/serial_control_properties.sv */
/* port checker for serial_control.
   assumes a bind onto serial_control; one clock domain. */
module serial_control_checker (
	input wire clk_in,
	input wire arst_n_in,
	input wire [2:0] addr_in,
	input wire [7:0] wdata_in,
	input wire wr_in,
	input wire rd_in,
	input wire [7:0] rdata_out,
	input wire tx_empty_irq_out,
	input wire rx_full_irq_out,
	input wire rx_error_irq_out,
	input wire irq_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!arst_n_in);
	// ----
	// properties
	// ----
	property p_irq_or;
		irq_out == (tx_empty_irq_out | rx_full_irq_out | rx_error_irq_out);
	endproperty
	a_irq_or: assert property (p_irq_or) else $error("irq not OR");
	property p_tx_off;
		wr_in && addr_in == 3'h0 && !wdata_in[7] |=> !tx_empty_irq_out;
	endproperty
	a_tx_off: assert property (p_tx_off) else $error("tx irq stays");
	property p_rx_off;
		wr_in && addr_in == 3'h0 && !wdata_in[6]
			|=> !rx_full_irq_out && !rx_error_irq_out;
	endproperty
	a_rx_off: assert property (p_rx_off) else $error("rx irq stays");
	// the forced flag may land one cycle after the enable
	property p_tx_force;
		wr_in && addr_in == 3'h0 && wdata_in[7] && !wdata_in[5]
			|=> (wr_in && addr_in == 3'h0) or (##1 tx_empty_irq_out);
	endproperty
	a_tx_force: assert property (p_tx_force) else $error("no tx irq");
	property p_readback;
		(wr_in && addr_in == 3'h0) ##1 !wr_in ##1 (rd_in && addr_in == 3'h0)
			|=> rdata_out == $past(wdata_in, 3);
	endproperty
	a_readback: assert property (p_readback) else $error("ctrl bad");
	property p_tx_fall;
		$fell(tx_empty_irq_out) |-> $past(wr_in);
	endproperty
	a_tx_fall: assert property (p_tx_fall) else $error("tx irq fell");
	property p_rx_fall;
		$fell(rx_full_irq_out) |-> $past(wr_in);
	endproperty
	a_rx_fall: assert property (p_rx_fall) else $error("rx irq fell");
	property p_err_hold;
		rx_error_irq_out && !wr_in |=> rx_error_irq_out;
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("err lost");
	c_tx: cover property (tx_empty_irq_out ##1 !tx_empty_irq_out);
	c_rx: cover property (rx_full_irq_out);
	c_err: cover property (rx_error_irq_out);
endmodule // serial_control_checker

bind serial_control serial_control_checker serial_control_checker_i (
	.clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in),
	.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
	.rdata_out(rdata_out), .tx_empty_irq_out(tx_empty_irq_out),
	.rx_full_irq_out(rx_full_irq_out), .rx_error_irq_out(rx_error_irq_out),
	.irq_out(irq_out));

/* test/serial_peer.sv */
/* remote serial peer: sends async or clocked frames, decodes txd.
   assumes 8 data bits, no parity, BIT_CLKS clocks a bit. */
module serial_peer #(parameter int BIT_CLKS = 4) (
	input wire clk_in,
	input wire txd_in,
	output logic rxd_out,
	output logic sck_out,
	output logic [7:0] byte_out,
	output int frames_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		rxd_out = 1'b1; // idle high, a start bit is the first low of an async frame
		sck_out = 1'b0;
		byte_out = 8'h00;
		frames_out = 0;
	end
	// stop = 0 gives a framing fault on purpose
	task automatic send(input logic [7:0] d, input logic stop);
		logic [9:0] f;
		f = {stop, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_in);
			rxd_out <= f[i];
			repeat (BIT_CLKS - 1) @(posedge clk_in);
		end
		@(posedge clk_in);
		rxd_out <= 1'b1;
		repeat (BIT_CLKS) @(posedge clk_in);
	endtask
	// clocked mode: data leads the rising sck by four clocks
	task automatic send_sync(input logic [7:0] d);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_in);
			rxd_out <= d[i];
			sck_out <= 1'b0;
			repeat (4) @(posedge clk_in);
			sck_out <= 1'b1;
			repeat (3) @(posedge clk_in);
		end
		@(posedge clk_in);
		sck_out <= 1'b0;
		rxd_out <= 1'b1;
		repeat (4) @(posedge clk_in);
	endtask
	// sample mid bit, away from the edge where txd moves
	initial forever begin
		@(negedge txd_in);
		repeat (BIT_CLKS / 2) @(posedge clk_in);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CLKS) @(posedge clk_in);
			byte_out[i] = txd_in;
		end
		frames_out++;
		repeat (BIT_CLKS) @(posedge clk_in);
	end
endmodule // serial_peer

/* test/testbench.sv */
/* testbench for serial_control: register tasks and a serial peer.
   assumes a 25 MHz clock and baud register 3 (4 clocks a bit). */
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic [2:0] addr_in = 3'h0;
	logic [7:0] wdata_in = 8'h00;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic [7:0] rdata_out, peer_byte, v;
	logic rxd_in, txd_out, tx_empty_irq_out, rx_full_irq_out;
	logic rx_error_irq_out, irq_out, sck_in;
	int peer_frames;
	int fail_count = 0;
	int compares = 0;
	always #20 clk_in = ~clk_in;
	serial_control serial_control_i (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_out), .rxd_in(rxd_in), .sck_in(sck_in),
		.txd_out(txd_out), .tx_empty_irq_out(tx_empty_irq_out),
		.rx_full_irq_out(rx_full_irq_out),
		.rx_error_irq_out(rx_error_irq_out), .irq_out(irq_out));
	serial_peer serial_peer_i (.clk_in(clk_in), .txd_in(txd_out),
		.rxd_out(rxd_in), .sck_out(sck_in), .byte_out(peer_byte),
		.frames_out(peer_frames));
	// ----
	// tasks, all entered just after a rising edge
	// ----
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge clk_in);
		wr_in <= 1'b0;
		// idle edge: a following write never re-raises the strobe
		// in the same time step that lowered it
		@(posedge clk_in);
	endtask
	task automatic rd(input logic [2:0] a);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_in);
		rd_in <= 1'b0;
		@(negedge clk_in);
		v = rdata_out;
		@(posedge clk_in);
	endtask
	// bits: 3 any, 2 tx empty, 1 rx full, 0 rx error
	task automatic irqs(input logic [7:0] e);
		@(negedge clk_in);
		chk({4'h0, irq_out, tx_empty_irq_out, rx_full_irq_out,
			rx_error_irq_out}, e);
		@(posedge clk_in);
	endtask
	task automatic final_report;
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ----
	// tests
	// ----
	initial begin
		repeat (6) @(posedge clk_in);
		arst_n_in <= 1'b1;
		@(posedge clk_in);
		rd(3'h0);
		chk(v, 8'h00);
		rd(3'h2);
		chk(v, 8'h84);
		wr(3'h6, 8'h03);
		wr(3'h1, 8'h00);
		wr(3'h2, 8'h7F);
		rd(3'h2);
		chk(v & 8'h80, 8'h80);
		wr(3'h0, 8'h80);
		irqs(8'h0C);
		wr(3'h0, 8'h00);
		irqs(8'h00);
		wr(3'h0, 8'hA0);
		wr(3'h3, 8'hA5);
		rd(3'h2);
		wr(3'h2, 8'h7F);
		for (int i = 0; i < 400 && peer_frames == 0; i++) @(posedge clk_in);
		chk(peer_byte, 8'hA5);
		wr(3'h0, 8'h50);
		serial_peer_i.send(8'h3C, 1'b1);
		for (int i = 0; i < 300 && !rx_full_irq_out; i++) @(posedge clk_in);
		irqs(8'h0A);
		rd(3'h4);
		chk(v, 8'h3C);
		rd(3'h2);
		wr(3'h2, 8'hBF);
		irqs(8'h00);
		serial_peer_i.send(8'h5A, 1'b0);
		for (int i = 0; i < 300 && !rx_error_irq_out; i++) @(posedge clk_in);
		wr(3'h0, 8'h40);
		rd(3'h2);
		chk(v & 8'h78, 8'h50);
		irqs(8'h0B);
		wr(3'h0, 8'h00);
		irqs(8'h00);
		rd(3'h2);
		wr(3'h2, 8'h87);
		wr(3'h1, 8'h80);
		wr(3'h0, 8'h50);
		serial_peer_i.send_sync(8'hC3);
		for (int i = 0; i < 50 && !rx_full_irq_out; i++) @(posedge clk_in);
		irqs(8'h0A);
		rd(3'h4);
		chk(v, 8'hC3);
		rd(3'h2);
		chk(v & 8'h78, 8'h40);
		wr(3'h7, 8'hFF);
		rd(3'h7);
		chk(v, 8'h00);
		wr(3'h0, 8'h0F);
		rd(3'h0);
		chk(v, 8'h0F);
		final_report();
	end
	// the tests need well under 2000 cycles
	initial begin
		repeat (20000) @(posedge clk_in);
		fail_count++;
		final_report();
	end
endmodule // testbench
